// ### rtl/usra_shared_ram.sv
`timescale 1ns/1ps
module usra_shared_ram #(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Processor side bus
  input wire logic cpu_sel_i,
  input wire logic cpu_ram_i,
  input wire logic cpu_wr_i,
  input wire logic [AW-1:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  output logic cpu_err_o,
  // Serial engine register space
  output logic sie_reg_sel_o,
  output logic sie_reg_wr_o,
  output logic [AW-1:0] sie_reg_addr_o,
  output logic [7:0] sie_reg_wdata_o,
  input wire logic [7:0] sie_reg_rdata_i,
  // Serial engine RAM port
  input wire logic sie_req_i,
  input wire logic sie_desc_i,
  input wire logic [3:0] sie_desc_idx_i,
  input wire logic [1:0] sie_desc_byte_i,
  input wire logic sie_wr_i,
  input wire logic [AW-1:0] sie_addr_i,
  input wire logic [7:0] sie_wdata_i,
  output logic [7:0] sie_rdata_o,
  output logic sie_ack_o,
  // Module and power controls
  input wire logic usb_en_i,
  input wire logic suspend_i,
  input wire logic deep_stop_i,
  input wire logic reg_en_i,
  input wire logic internal_pullup_enable_i,
  input wire logic vbus_pin_i,
  output logic [1:0] reg_mode_o,
  output logic dplus_pullup_o
);

  ////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [AW-1:0] desc_addr(input logic [3:0] idx, input logic [1:0] b);
    desc_addr = AW'(idx * usra_pkg::DESC_BYTES + b);
  endfunction

  function automatic logic in_desc(input logic [AW-1:0] a);
    in_desc = (a <= AW'(usra_pkg::DESC_LAST));
  endfunction

  ////////////////////////////////////////////////////////////////
  // Storage, both slots of one bus cycle happen at this edge
  logic [7:0] mem_r [usra_pkg::RAM_BYTES];
  logic [AW-1:0] sie_phys;
  logic cpu_lock;
  logic cpu_ram_go;
  logic [1:0] vbus_sync_r;
  logic act_now;

  // Descriptor index to physical byte
  assign sie_phys = sie_desc_i ? desc_addr(sie_desc_idx_i, sie_desc_byte_i)
                               : sie_addr_i;
  // Processor blocked from writing a descriptor the module owns
  assign cpu_lock = usb_en_i && in_desc(cpu_addr_i) && cpu_wr_i
                    && mem_r[cpu_addr_i - (cpu_addr_i % AW'(usra_pkg::DESC_BYTES))]
                       [usra_pkg::OWN_BIT];
  assign cpu_ram_go = cpu_sel_i && cpu_ram_i && !cpu_lock;

  // Processor slot first, serial engine slot second
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i) begin
      if (cpu_ram_go && cpu_wr_i) begin
        mem_r[cpu_addr_i] <= cpu_wdata_i;
      end
      if (usb_en_i && sie_req_i && sie_wr_i) begin
        mem_r[sie_phys] <= sie_wdata_i;
      end
    end
  end

  // Processor answer
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_rdata_o <= usra_pkg::RDATA_RST;
      cpu_err_o <= 1'b0;
    end else if (clk_en_i) begin
      cpu_err_o <= cpu_sel_i && cpu_ram_i && cpu_lock;
      if (cpu_sel_i && cpu_ram_i) begin
        cpu_rdata_o <= mem_r[cpu_addr_i];
      end else if (cpu_sel_i) begin
        cpu_rdata_o <= sie_reg_rdata_i;
      end
    end
  end

  // Register space routing
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sie_reg_sel_o <= 1'b0;
      sie_reg_wr_o <= 1'b0;
      sie_reg_addr_o <= '0;
      sie_reg_wdata_o <= usra_pkg::RDATA_RST;
    end else if (clk_en_i) begin
      sie_reg_sel_o <= cpu_sel_i && !cpu_ram_i;
      sie_reg_wr_o <= cpu_sel_i && !cpu_ram_i && cpu_wr_i;
      sie_reg_addr_o <= cpu_addr_i;
      sie_reg_wdata_o <= cpu_wdata_i;
    end
  end

  // Serial engine answer, granted every cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sie_rdata_o <= usra_pkg::RDATA_RST;
      sie_ack_o <= 1'b0;
    end else if (clk_en_i) begin
      sie_ack_o <= usb_en_i && sie_req_i;
      if (usb_en_i && sie_req_i) begin
        sie_rdata_o <= (cpu_ram_go && cpu_wr_i && cpu_addr_i == sie_phys)
                       ? cpu_wdata_i : mem_r[sie_phys];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Bus supply sense synchroniser
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vbus_sync_r <= 2'b00;
    end else if (clk_en_i) begin
      vbus_sync_r <= {vbus_sync_r[0], vbus_pin_i};
    end
  end

  assign act_now = usb_en_i && reg_en_i && !deep_stop_i;

  // Regulator mode and pull-up
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_mode_o <= 2'(usra_pkg::USRA_REG_OFF);
      dplus_pullup_o <= 1'b0;
    end else if (clk_en_i) begin
      if (!reg_en_i || deep_stop_i) begin
        reg_mode_o <= 2'(usra_pkg::USRA_REG_OFF);
      end else if (suspend_i) begin
        reg_mode_o <= 2'(usra_pkg::USRA_REG_STBY);
      end else if (usb_en_i) begin
        reg_mode_o <= 2'(usra_pkg::USRA_REG_ACT);
      end else begin
        reg_mode_o <= 2'(usra_pkg::USRA_REG_OFF);
      end
      dplus_pullup_o <= internal_pullup_enable_i && vbus_sync_r[1]
                        && usb_en_i;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  reg_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && (!reg_en_i || deep_stop_i) |=> reg_mode_o == 2'(usra_pkg::USRA_REG_OFF))
    else $error("regulator not off");
  reg_stby_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && reg_en_i && !deep_stop_i && suspend_i
      |=> reg_mode_o == 2'(usra_pkg::USRA_REG_STBY))
    else $error("regulator not standby");
  reg_act_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && act_now && !suspend_i |=> reg_mode_o == 2'(usra_pkg::USRA_REG_ACT))
    else $error("regulator not active");
  pullup_en_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && !internal_pullup_enable_i |=> !dplus_pullup_o)
    else $error("pullup on while disabled");
  pullup_vbus_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    dplus_pullup_o |-> $past(vbus_sync_r[1]))
    else $error("pullup without supply");
  sie_grant_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && usb_en_i && sie_req_i |=> sie_ack_o)
    else $error("serial engine stalled");
  reg_route_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && cpu_sel_i && cpu_ram_i |=> !sie_reg_sel_o)
    else $error("ram access leaked to registers");
  ram_route_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && cpu_sel_i && cpu_ram_i && !cpu_wr_i
      ##1 clk_en_i && cpu_sel_i && cpu_ram_i && !cpu_wr_i
      && cpu_addr_i == $past(cpu_addr_i) && !(usb_en_i && sie_req_i && sie_wr_i)
      && !$past(usb_en_i && sie_req_i && sie_wr_i)
      |=> cpu_rdata_o == $past(cpu_rdata_o))
    else $error("ram read unstable");
  own_lock_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && cpu_lock && cpu_sel_i && cpu_ram_i |=> cpu_err_o)
    else $error("owned descriptor not refused");
endmodule

// ### inc/usra_pkg.sv
// What this block does
// - Descriptor and buffer accesses go to shared RAM
// - Register accesses go to serial engine space
// - Descriptor requests map to physical RAM addresses
// - Arbiter serves processor gasket and serial engine
// - Shared RAM holds 256 bytes, both read/write
// - RAM runs double rate, no requester stalls
// - Unassigned RAM stays usable as system memory
// - Disabled module leaves whole RAM to processor
// - Active regulator mode while USB function active
// - Standby regulator mode automatically during suspend
// - Power-off on deep stop or regulator disabled
// - Cleared enable disconnects internal D+ pull-up
// - Pull-up only while bus supply sensed
// - Owner bit set locks descriptor from processor writes while module enabled
// - Descriptor table 0x00-0x1d, buffers from 0x20
package usra_pkg;
  // Shared RAM layout
  localparam int RAM_BYTES = 256;
  localparam logic [7:0] DESC_FIRST = 8'h00;
  localparam logic [7:0] DESC_LAST = 8'h1d;
  localparam logic [7:0] BUF_FIRST = 8'h20;
  localparam logic [7:0] DESC_BYTES = 8'h03;
  // Descriptor status byte: owner semaphore position
  localparam int OWN_BIT = 7;
  // Reset values
  localparam logic [7:0] RDATA_RST = 8'h00;
  // Regulator modes
  typedef enum logic [1:0] {USRA_REG_OFF, USRA_REG_STBY, USRA_REG_ACT} usra_reg_mode_t;
endpackage

// ### dv/usra_cpu_model.sv
`timescale 1ns/1ps
module usra_cpu_model (
  // Bus clock
  input wire logic ref_clk_i,
  // Processor access lines
  output logic sel_o,
  output logic ram_o,
  output logic wr_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // Idle bus from time zero
  initial begin
    sel_o = 1'b0;
    ram_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // Start one byte access; the caller stands at a falling edge
  task automatic go(input logic w, r, input logic [7:0] a, d);
    sel_o = 1'b1;
    ram_o = r;
    wr_o = w;
    addr_o = a;
    wdata_o = d;
  endtask
  // Hold over the taking edge; the next access may follow at once
  task automatic done();
    @(negedge ref_clk_i);
  endtask
  // Release the bus with inverted address and data lines; call at a falling edge after done
  task automatic idle();
    sel_o = 1'b0;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask
endmodule

// ### dv/usb_shared_ram_access_test.sv
`timescale 1ns/1ps
module usb_shared_ram_access_test;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cpu_sel_i, cpu_ram_i, cpu_wr_i, cpu_err_o, sie_reg_sel_o, sie_req_i, sie_desc_i, sie_wr_i;
  logic [7:0] cpu_addr_i, cpu_wdata_i, cpu_rdata_o, sie_reg_addr_o, sie_reg_rdata_i;
  logic [7:0] sie_addr_i, sie_wdata_i, sie_rdata_o;
  logic [3:0] sie_desc_idx_i;
  logic [1:0] sie_desc_byte_i, reg_mode_o;
  logic sie_ack_o, usb_en_i, suspend_i, deep_stop_i, reg_en_i, internal_pullup_enable_i;
  logic vbus_pin_i, dplus_pullup_o, sie_reg_wr_o;
  logic [7:0] sie_reg_wdata_o;
  logic clk_en_i = 1'b1;
  int n_fail = 0;
  int n_compared = 0;
  logic [7:0] mem [256];
  // Bus clock, 100 ns period
  always #50 ref_clk_i = ~ref_clk_i;
  usra_cpu_model cpu (.ref_clk_i, .sel_o(cpu_sel_i), .ram_o(cpu_ram_i), .wr_o(cpu_wr_i),
    .addr_o(cpu_addr_i), .wdata_o(cpu_wdata_i));
  usra_shared_ram #(.AW(8)) uut (.ref_clk_i, .rst_n_i, .clk_en_i, .cpu_sel_i, .cpu_ram_i,
    .cpu_wr_i, .cpu_addr_i, .cpu_wdata_i, .cpu_rdata_o, .cpu_err_o, .sie_reg_sel_o,
    .sie_reg_wr_o, .sie_reg_addr_o, .sie_reg_wdata_o, .sie_reg_rdata_i, .sie_req_i,
    .sie_desc_i, .sie_desc_idx_i, .sie_desc_byte_i, .sie_wr_i, .sie_addr_i, .sie_wdata_i,
    .sie_rdata_o, .sie_ack_o, .usb_en_i, .suspend_i, .deep_stop_i, .reg_en_i,
    .internal_pullup_enable_i, .vbus_pin_i, .reg_mode_o, .dplus_pullup_o);
  // Comparisons
  task automatic chk_byte(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One cycle with a processor access and an optional engine request, against the model
  task automatic step(input logic cwr, cram, input logic [7:0] ca, cd, input logic sreq);
    logic [7:0] sa;
    logic [7:0] sx;
    logic ce;
    sa = sie_desc_i ? 8'(sie_desc_idx_i * 3 + sie_desc_byte_i) : sie_addr_i;
    sx = mem[sa];
    ce = cwr && cram && usb_en_i && ca <= 8'h1d && mem[ca / 3 * 3][7] === 1'b1;
    sie_reg_rdata_i = 8'($urandom);
    cpu.go(cwr, cram, ca, cd);
    sie_req_i = sreq;
    cpu.done();
    if (!cwr) chk_byte(cpu_rdata_o, cram ? mem[ca] : sie_reg_rdata_i);
    chk_bit(sie_reg_sel_o, !cram);
    chk_bit(sie_reg_wr_o, !cram && cwr);
    if (!cram && cwr) chk_byte(sie_reg_wdata_o, cd);
    if (!cram) chk_byte(sie_reg_addr_o, ca);
    if (cram) chk_bit(cpu_err_o, ce);
    if (cwr && cram && !ce) mem[ca] = cd;
    chk_bit(sie_ack_o, sreq && usb_en_i);
    if (sreq && usb_en_i && !sie_wr_i) chk_byte(sie_rdata_o, sx);
    if (sreq && usb_en_i && sie_wr_i) mem[sa] = sie_wdata_i;
  endtask
  // Hang guard
  initial begin
    #1000000;
    n_fail++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    int i;
    {sie_req_i, sie_desc_i, sie_desc_idx_i, sie_desc_byte_i, sie_wr_i, sie_addr_i} = '0;
    {sie_wdata_i, sie_reg_rdata_i, usb_en_i, suspend_i, deep_stop_i, reg_en_i} = '0;
    {internal_pullup_enable_i, vbus_pin_i} = '0;
    void'($urandom(49));
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    for (i = 0; i < 9; i++) step(1'b1, 1'b1, 8'(i * 30), 8'($urandom), 1'b1);
    for (i = 0; i < 9; i++) step(1'b0, 1'b1, 8'(i * 30), 8'h00, 1'b0);
    $display("test disabled_ram done");
    usb_en_i = 1'b1;
    sie_desc_i = 1'b1;
    sie_wr_i = 1'b1;
    for (i = 0; i < 30; i++) begin
      sie_desc_idx_i = 4'(i / 3);
      sie_desc_byte_i = 2'(i % 3);
      sie_wdata_i = 8'($urandom) & ((i % 3 == 0) ? 8'h7f : 8'hff);
      step(i[0], 1'b0, 8'(i), 8'($urandom), 1'b1);
    end
    sie_desc_i = 1'b0;
    for (i = 0; i < 30; i++) begin
      sie_addr_i = 8'(32 + i);
      sie_wdata_i = 8'($urandom);
      step(1'b0, 1'b1, 8'(i), 8'h00, 1'b1);
    end
    sie_wr_i = 1'b0;
    for (i = 0; i < 30; i++) begin
      sie_addr_i = 8'(32 + i);
      step(1'b1, 1'b1, 8'(96 + i), 8'($urandom), 1'b1);
    end
    $display("test shared_access done");
    sie_desc_i = 1'b1;
    sie_wr_i = 1'b1;
    sie_desc_idx_i = 4'h2;
    sie_desc_byte_i = 2'h0;
    sie_wdata_i = 8'h80;
    step(1'b0, 1'b0, 8'h00, 8'h00, 1'b1);
    step(1'b1, 1'b1, 8'h07, 8'h5a, 1'b0);
    step(1'b1, 1'b1, 8'h1e, 8'h3c, 1'b0);
    step(1'b0, 1'b1, 8'h07, 8'h00, 1'b0);
    sie_req_i = 1'b0;
    cpu.idle();
    $display("test owner_lock done");
    // Suspend cases stand for the shallowest stop, deep stop for the deeper ones
    for (i = 0; i < 16; i++) begin
      {usb_en_i, suspend_i, deep_stop_i, reg_en_i} = 4'(i);
      repeat (2) @(negedge ref_clk_i);
      chk_byte({6'h00, reg_mode_o}, (!reg_en_i || deep_stop_i) ? 8'h00 : suspend_i ? 8'h01 :
        usb_en_i ? 8'h02 : 8'h00);
    end
    // Frozen clock enable holds the regulator mode
    clk_en_i = 1'b0;
    {usb_en_i, suspend_i, deep_stop_i, reg_en_i} = 4'b1001;
    repeat (2) @(negedge ref_clk_i);
    chk_byte({6'h00, reg_mode_o}, 8'h00);
    clk_en_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    chk_byte({6'h00, reg_mode_o}, 8'h02);
    // All eight enable, pull-up enable and supply combinations, driven together and checked five cycles later
    for (i = 0; i < 8; i++) begin
      {usb_en_i, internal_pullup_enable_i, vbus_pin_i} = 3'(i);
      repeat (5) @(negedge ref_clk_i);
      chk_bit(dplus_pullup_o, usb_en_i && internal_pullup_enable_i && vbus_pin_i);
    end
    $display("test power_pullup done");
    report_and_stop();
  end
endmodule
